// >>> inc/afic_regs.svh
// register offsets, field positions and reset values of the analog front end
`ifndef AFIC_REGS_SVH
`define AFIC_REGS_SVH

// ==========================================================================
// offsets
`define AFIC_ANALOG_CTRL_A_OFF  12'h000
`define AFIC_ANALOG_CTRL_B_OFF  12'h004
`define AFIC_POWER_CTRL_OFF     12'h008
`define AFIC_DAC_CODE_OFF       12'h00c
`define AFIC_STATUS_OFF         12'h010
`define AFIC_PORT_A_OUT_OFF     12'h014
`define AFIC_PORT_B_OUT_OFF     12'h018
`define AFIC_PORT_IN_OFF        12'h01c

// ==========================================================================
// fields of analog_ctrl_a
`define AFIC_REG_EN_BIT         1
`define AFIC_BIAS_ROUTE_BIT     3
`define AFIC_SOURCE_ROUTE_BIT   4
`define AFIC_RAMP_PD_BIT        5
`define AFIC_SW_DAC_ROUTE_BIT   6
// fields of analog_ctrl_b
`define AFIC_CMP_SEL_LSB        0
`define AFIC_CAPTURE_SEL_BIT    3
// fields of power_ctrl
`define AFIC_IDLE_REQ_BIT       0
// fields of status
`define AFIC_IDLE_BIT           0
`define AFIC_CMP_BIT            1
`define AFIC_CLK_PHASE_BIT      2

// ==========================================================================
// reset values
`define AFIC_ANALOG_CTRL_A_RST  8'h00
`define AFIC_ANALOG_CTRL_B_RST  8'h00
`define AFIC_DAC_CODE_RST       8'h00
`define AFIC_PORT_A_RST         3'h7
`define AFIC_PORT_B_RST         8'hff

`endif

// >>> inc/afic_pkg.sv
// types shared by the analog front end and idle control files
package afic_pkg;
	typedef enum logic [1:0] {
		AFIC_RUN  = 2'b01,
		AFIC_IDLE = 2'b10
	} afic_pwr_state_t;

	typedef enum logic [2:0] {
		AFIC_CMP_NONE = 3'h0,
		AFIC_CMP_X    = 3'h1,
		AFIC_CMP_Y    = 3'h2,
		AFIC_CMP_Z    = 3'h4
	} afic_cmp_sel_t;
endpackage

// >>> rtl/afic_sync2.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module afic_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// meta_reg feeds only sync_out
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // afic_sync2
`default_nettype wire

// >>> rtl/afic_clkdiv.sv
// divide-by-two enable from the oscillator-rate clock
`timescale 1ns/1ps
`default_nettype none
module afic_clkdiv (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// core rate
	output logic      core_en
);
	// a toggle stage makes core timing independent of input duty cycle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			core_en <= 1'b0;
		end else begin
			core_en <= ~core_en; // see R01
		end
	end
endmodule // afic_clkdiv
`default_nettype wire

// >>> rtl/afic_top.sv
// analog front end control, idle mode and port pins behind an apb slave
// Operation
// R01: core clock is oscillator divided by two
// R02: idle stops core, peripherals except dac run
// R03: timers and interrupts keep running in idle
// R04: idle starts after requesting instruction completes
// R05: registers and memory retained during idle
// R06: enabled interrupt ends idle, vectors to handler
// R07: hardware reset ends idle like power-on
// R08: firmware waits for references before conversion
// R09: first port three bits, open-drain third
// R10: second port eight bidirectional bits
// R11: regulator enable bit switches bandgap regulator
// R12: separate bits route regulator to bias, source
// R13: eight-bit code, fixed output always driven
// R14: routing bit adds switched converter output
// R15: three-way select feeds comparator positive input
// R16: comparator can trigger array capture
// R17: pulldown bit enables ramp pulldown
// R18: all analog controls reset to zero
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "afic_regs.svh"
module afic_top
	import afic_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// core handshake
	input  wire logic        instr_done,
	input  wire logic        irq_pending,
	output logic             core_en,
	output logic             core_run_en,
	output logic             irq_vector_req,
	output logic             periph_en,
	// analog front end
	input  wire logic        cmp_in_x,
	input  wire logic        cmp_in_y,
	input  wire logic        cmp_in_z,
	input  wire logic        bandgap_ref,
	output logic             regulator_enable,
	output logic             bias_route_enable,
	output logic             source_route_enable,
	output logic             ramp_pulldown_enable,
	output logic             switched_dac_route_enable,
	output logic      [7:0]  dac_code,
	output logic             dac_active,
	output logic      [2:0]  comparator_input_select,
	output logic             capture_trigger,
	// first port
	input  wire logic [2:0]  port_a_in,
	output logic      [2:0]  port_a_out,
	output logic      [2:0]  port_a_oe_b,
	output logic             ext_irq_zero,
	input  wire logic        array_clock_out,
	// second port
	input  wire logic [7:0]  port_b_in,
	output logic      [7:0]  port_b_out,
	output logic      [7:0]  port_b_oe_b,
	output logic             ext_irq_one,
	output logic             timer_zero_ext_clk,
	output logic             timer_one_ext_clk,
	output logic             array_ext_clock_in,
	output logic             serial_rx
);
	// ======================================================================
	// declarations
	logic [7:0]      analog_ctrl_a_reg;
	logic [7:0]      analog_ctrl_b_reg;
	logic [7:0]      dac_code_reg;
	logic [2:0]      port_a_reg;
	logic [7:0]      port_b_reg;
	logic            idle_req_reg;
	afic_pwr_state_t pwr_state_reg;
	afic_pwr_state_t pwr_state_next;
	logic [2:0]      port_a_sync;
	logic [7:0]      port_b_sync;
	logic [3:0]      analog_sync;
	logic            cmp_pos;
	logic            cmp_out;
	logic            wr_en;
	logic            rd_en;
	logic            addr_ok;
	logic [31:0]     rd_data;

	// ======================================================================
	// clock divider and synchronisers
	afic_clkdiv u_clkdiv (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.core_en (core_en)
	);

	afic_sync2 #(.WIDTH(3)) u_sync_a (
		.clk_sys  (clk_sys),
		.rst_b    (rst_b),
		.async_in (port_a_in),
		.sync_out (port_a_sync)
	);

	afic_sync2 #(.WIDTH(8)) u_sync_b (
		.clk_sys  (clk_sys),
		.rst_b    (rst_b),
		.async_in (port_b_in),
		.sync_out (port_b_sync)
	);

	// comparator inputs and reference are asynchronous analog levels
	afic_sync2 #(.WIDTH(4)) u_sync_cmp (
		.clk_sys  (clk_sys),
		.rst_b    (rst_b),
		.async_in ({bandgap_ref, cmp_in_z, cmp_in_y, cmp_in_x}),
		.sync_out (analog_sync)
	);

	// ======================================================================
	// apb decode: zero wait states, unmapped offsets error
	always_comb begin
		case (paddr)
			`AFIC_ANALOG_CTRL_A_OFF,
			`AFIC_ANALOG_CTRL_B_OFF,
			`AFIC_POWER_CTRL_OFF,
			`AFIC_DAC_CODE_OFF,
			`AFIC_STATUS_OFF,
			`AFIC_PORT_A_OUT_OFF,
			`AFIC_PORT_B_OUT_OFF,
			`AFIC_PORT_IN_OFF: addr_ok = 1'b1;
			default:           addr_ok = 1'b0;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign wr_en   = psel & penable & pwrite & addr_ok;
	assign rd_en   = psel & ~penable & ~pwrite;

	// ======================================================================
	// analog control registers, held through idle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			analog_ctrl_a_reg <= `AFIC_ANALOG_CTRL_A_RST; // see R18
			analog_ctrl_b_reg <= `AFIC_ANALOG_CTRL_B_RST; // see R18
			dac_code_reg      <= `AFIC_DAC_CODE_RST;
		end else if (wr_en) begin // see R05
			if (paddr == `AFIC_ANALOG_CTRL_A_OFF) begin
				analog_ctrl_a_reg <= pwdata[7:0];
			end
			if (paddr == `AFIC_ANALOG_CTRL_B_OFF) begin
				analog_ctrl_b_reg <= pwdata[7:0];
			end
			if (paddr == `AFIC_DAC_CODE_OFF) begin
				dac_code_reg <= pwdata[7:0]; // see R13
			end
		end
	end

	// ======================================================================
	// port output latches
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			port_a_reg <= `AFIC_PORT_A_RST;
			port_b_reg <= `AFIC_PORT_B_RST;
		end else if (wr_en) begin
			if (paddr == `AFIC_PORT_A_OUT_OFF) begin
				port_a_reg <= pwdata[2:0];
			end
			if (paddr == `AFIC_PORT_B_OUT_OFF) begin
				port_b_reg <= pwdata[7:0];
			end
		end
	end

	// ======================================================================
	// idle request: cleared by hardware on entry; write wins a collision
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			idle_req_reg <= 1'b0;
		end else if (wr_en && paddr == `AFIC_POWER_CTRL_OFF) begin
			idle_req_reg <= pwdata[`AFIC_IDLE_REQ_BIT];
		end else if (pwr_state_reg == AFIC_IDLE) begin
			idle_req_reg <= 1'b0;
		end
	end

	// ======================================================================
	// power state machine on the core-rate enable
	always_comb begin
		pwr_state_next = pwr_state_reg;
		case (pwr_state_reg)
			AFIC_RUN: begin
				// wait for the requesting instruction to retire
				if (idle_req_reg && instr_done && !irq_pending) begin
					pwr_state_next = AFIC_IDLE; // see R04
				end
			end
			AFIC_IDLE: begin
				if (irq_pending) begin
					pwr_state_next = AFIC_RUN; // see R06
				end
			end
			default: pwr_state_next = AFIC_RUN;
		endcase
	end

	// asynchronous reset drops straight back to run
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pwr_state_reg <= AFIC_RUN; // see R07
		end else if (core_en) begin
			pwr_state_reg <= pwr_state_next;
		end
	end

	// vector request pulses for one cycle on wake
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq_vector_req <= 1'b0;
		end else begin
			irq_vector_req <= core_en && pwr_state_reg == AFIC_IDLE
				&& irq_pending; // see R06
		end
	end

	assign core_run_en = core_en & (pwr_state_reg == AFIC_RUN); // see R02
	assign periph_en   = core_en; // see R03
	assign dac_active  = pwr_state_reg == AFIC_RUN; // see R02

	// ======================================================================
	// analog outputs
	assign regulator_enable          =
		analog_ctrl_a_reg[`AFIC_REG_EN_BIT]; // see R11
	assign bias_route_enable         =
		analog_ctrl_a_reg[`AFIC_BIAS_ROUTE_BIT]; // see R12
	assign source_route_enable       =
		analog_ctrl_a_reg[`AFIC_SOURCE_ROUTE_BIT]; // see R12
	assign ramp_pulldown_enable      =
		analog_ctrl_a_reg[`AFIC_RAMP_PD_BIT]; // see R17
	assign switched_dac_route_enable =
		analog_ctrl_a_reg[`AFIC_SW_DAC_ROUTE_BIT]; // see R14
	assign dac_code                  = dac_code_reg; // see R13
	assign comparator_input_select   =
		analog_ctrl_b_reg[`AFIC_CMP_SEL_LSB +: 3]; // see R15

	// one-hot select; unlisted codes pick nothing, leaving the input low
	always_comb begin
		case (afic_cmp_sel_t'(comparator_input_select))
			AFIC_CMP_X: cmp_pos = analog_sync[0]; // see R15
			AFIC_CMP_Y: cmp_pos = analog_sync[1];
			AFIC_CMP_Z: cmp_pos = analog_sync[2];
			default:    cmp_pos = 1'b0;
		endcase
	end

	assign cmp_out = cmp_pos & ~analog_sync[3];

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			capture_trigger <= 1'b0;
		end else begin
			capture_trigger <= cmp_out
				& analog_ctrl_b_reg[`AFIC_CAPTURE_SEL_BIT]; // see R16
		end
	end

	// ======================================================================
	// ports: oe_b low drives; pulled-up bits drive high, third bit only low
	// bit 1 carries the array clock out, gated by its latch: software
	// must leave that latch high or the clock never reaches the pin
	assign port_a_out[0]  = port_a_reg[0];
	assign port_a_out[1]  = port_a_reg[1] & array_clock_out; // see R09
	assign port_a_out[2]  = port_a_reg[2];
	assign port_a_oe_b[0] = 1'b0; // see R09
	assign port_a_oe_b[1] = 1'b0;
	assign port_a_oe_b[2] = port_a_reg[2]; // see R09
	assign port_b_out     = port_b_reg; // see R10
	assign port_b_oe_b    = port_b_reg; // quasi-bidirectional: high floats

	assign ext_irq_zero       = port_a_sync[0]; // see R09
	assign serial_rx          = port_b_sync[0]; // see R10
	assign ext_irq_one        = port_b_sync[2];
	assign timer_zero_ext_clk = port_b_sync[3];
	assign timer_one_ext_clk  = port_b_sync[4];
	assign array_ext_clock_in = port_b_sync[5];

	// ======================================================================
	// read data, registered in setup so it stands in the access phase
	always_comb begin
		rd_data = 32'h0000_0000;
		case (paddr)
			`AFIC_ANALOG_CTRL_A_OFF: rd_data[7:0] = analog_ctrl_a_reg;
			`AFIC_ANALOG_CTRL_B_OFF: rd_data[7:0] = analog_ctrl_b_reg;
			`AFIC_POWER_CTRL_OFF:    rd_data[0]   = idle_req_reg;
			`AFIC_DAC_CODE_OFF:      rd_data[7:0] = dac_code_reg;
			`AFIC_STATUS_OFF: begin
				rd_data[`AFIC_IDLE_BIT]      = pwr_state_reg == AFIC_IDLE;
				rd_data[`AFIC_CMP_BIT]       = cmp_out;
				rd_data[`AFIC_CLK_PHASE_BIT] = core_en;
			end
			`AFIC_PORT_A_OUT_OFF:    rd_data[2:0] = port_a_reg;
			`AFIC_PORT_B_OUT_OFF:    rd_data[7:0] = port_b_reg;
			`AFIC_PORT_IN_OFF: begin
				rd_data[2:0]  = port_a_sync;
				rd_data[15:8] = port_b_sync;
			end
			default:                 rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= rd_data;
		end
	end

endmodule // afic_top
`default_nettype wire

// >>> dv/afic_top_checker.sv
// port-level assertions for the analog front end and idle control
`timescale 1ns/1ps
`default_nettype none
module afic_top_checker (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_b,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pslverr,
	// core and analog
	input wire logic        instr_done,
	input wire logic        irq_pending,
	input wire logic        core_en,
	input wire logic        core_run_en,
	input wire logic        irq_vector_req,
	input wire logic        periph_en,
	input wire logic        dac_active,
	input wire logic [7:0]  dac_code,
	input wire logic        regulator_enable,
	input wire logic [2:0]  port_a_oe_b
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_core_div: assert property (rst_b |=> core_en != $past(core_en))
		else $error("core rate enable did not toggle");
	a_periph_run: assert property (periph_en == core_en)
		else $error("peripheral enable left the core rate");
	a_core_gate: assert property (core_run_en == (core_en && dac_active))
		else $error("core ran while idle");
	a_idle_after: assert property ($fell(dac_active) |->
		$past(instr_done) && $past(core_en) && !$past(irq_pending))
		else $error("idle entered before instruction end");
	a_wake_vec: assert property ($rose(dac_active) |-> ##[0:1] irq_vector_req)
		else $error("wake without vector request");
	a_vec_pulse: assert property (irq_vector_req |=> !irq_vector_req)
		else $error("vector request longer than one cycle");
	a_dac_hold: assert property (!(psel && penable && pwrite &&
		paddr == 12'h00c) |=> $stable(dac_code))
		else $error("dac code changed without a write");
	a_reg_hold: assert property (!(psel && penable && pwrite &&
		paddr == 12'h000) |=> $stable(regulator_enable))
		else $error("regulator enable changed without a write");
	a_bad_addr: assert property (psel && penable && paddr >= 12'h020 |-> pslverr)
		else $error("unmapped access not refused");
	a_port_pull: assert property (port_a_oe_b[1:0] == 2'b00)
		else $error("pulled-up port bits not driven");
endmodule // afic_top_checker
bind afic_top afic_top_checker u_chk (.clk_sys, .rst_b, .psel, .penable,
	.pwrite, .paddr, .pslverr, .instr_done, .irq_pending, .core_en,
	.core_run_en, .irq_vector_req, .periph_en, .dac_active, .dac_code,
	.regulator_enable, .port_a_oe_b);
`default_nettype wire

// >>> dv/afic_stick_model.sv
// sensor stick and bias circuit feeding the comparator inputs
`timescale 1ns/1ps
`default_nettype none
module afic_stick_model (
	// powering from the device
	input  wire logic       regulator_enable,
	input  wire logic       bias_route_enable,
	// deflection levels z y x
	input  wire logic [2:0] deflect,
	// level behind the comparator's negative input
	input  wire logic       ref_level,
	// comparator side
	output logic            cmp_in_x,
	output logic            cmp_in_y,
	output logic            cmp_in_z,
	output logic            bandgap_ref
);
	// an unbiased stick gives no signal, so levels need regulator and bias
	assign {cmp_in_z, cmp_in_y, cmp_in_x} =
		(regulator_enable && bias_route_enable) ? deflect : 3'h0;
	assign bandgap_ref = ref_level;
endmodule // afic_stick_model
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the analog front end and idle control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import afic_pkg::*;
	logic clk_sys, rst_b, psel, penable, pwrite, instr_done, irq_pending;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, core_en, core_run_en, irq_vector_req;
	logic periph_en, cmp_in_x, cmp_in_y, cmp_in_z, bandgap_ref;
	logic regulator_enable, bias_route_enable, source_route_enable;
	logic ramp_pulldown_enable, switched_dac_route_enable, dac_active;
	logic capture_trigger, ext_irq_zero, ext_irq_one, serial_rx;
	logic timer_zero_ext_clk, timer_one_ext_clk, array_ext_clock_in;
	logic [7:0] dac_code, port_b_in, port_b_out, port_b_oe_b, ext_b;
	logic [2:0] comparator_input_select, port_a_in, port_a_out, port_a_oe_b;
	logic [2:0] ext_a, deflect;
	logic array_clock_out, ref_level;
	int fails, comparisons;
	// pins are wired-and of external drivers and the device
	assign port_a_in = ext_a & (port_a_out | port_a_oe_b);
	assign port_b_in = ext_b & (port_b_out | port_b_oe_b);
	afic_top uut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .instr_done, .irq_pending,
		.core_en, .core_run_en, .irq_vector_req, .periph_en, .cmp_in_x,
		.cmp_in_y, .cmp_in_z, .bandgap_ref, .regulator_enable,
		.bias_route_enable, .source_route_enable, .ramp_pulldown_enable,
		.switched_dac_route_enable, .dac_code, .dac_active,
		.comparator_input_select, .capture_trigger, .port_a_in, .port_a_out,
		.port_a_oe_b, .ext_irq_zero, .array_clock_out, .port_b_in,
		.port_b_out, .port_b_oe_b, .ext_irq_one, .timer_zero_ext_clk,
		.timer_one_ext_clk, .array_ext_clock_in, .serial_rx);
	afic_stick_model u_stick (.regulator_enable, .bias_route_enable,
		.deflect, .ref_level, .cmp_in_x, .cmp_in_y, .cmp_in_z, .bandgap_ref);
	// ==========================================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// entered just after a rising edge; leaves one idle cycle behind
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wait_idle(input logic v);
		repeat (20) if (dac_active !== v) @(posedge clk_sys);
	endtask
	// ==========================================================================
	// scenarios
	task automatic t_reset;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		chk(32'({regulator_enable, bias_route_enable, source_route_enable,
			ramp_pulldown_enable, switched_dac_route_enable}), 32'h0);
		chk(32'({port_a_out, port_b_out, port_b_oe_b}), 32'h7ffff);
	endtask
	task automatic t_analog;
		int pos [5] = '{1, 3, 4, 5, 6};
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 12'h000, 32'h1 << pos[i]);
			chk(32'({switched_dac_route_enable, ramp_pulldown_enable,
				source_route_enable, bias_route_enable, 1'b0,
				regulator_enable, 1'b0}), 32'h1 << pos[i]);
		end
		apb(1'b1, 12'h00c, 32'h5a);
		chk(32'(dac_code), 32'h5a);
	endtask
	task automatic t_cmp;
		logic [2:0] sel;
		apb(1'b1, 12'h000, 32'h0a);
		for (int i = 0; i < 4; i++) begin
			sel = (i == 0) ? 3'h0 : 3'h1 << (i - 1);
			apb(1'b1, 12'h004, 32'(sel) | 32'h8);
			chk(32'(comparator_input_select), 32'(sel));
			for (int hit = 1; hit >= 0; hit--) begin
				deflect <= hit ? sel : ~sel;
				repeat (4) @(posedge clk_sys);
				apb(1'b0, 12'h010, 32'h0);
				chk(rd & 32'h2, (hit && i) ? 32'h2 : 32'h0);
				chk(32'(capture_trigger), 32'(hit && i));
			end
		end
		ref_level <= 1'b1;
		deflect <= 3'h4;
		repeat (4) @(posedge clk_sys);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd & 32'h2, 32'h0);
		chk(32'(capture_trigger), 32'h0);
		ref_level <= 1'b0;
	endtask
	task automatic t_idle;
		int n;
		apb(1'b1, 12'h008, 32'h1);
		repeat (6) @(posedge clk_sys);
		chk(32'(dac_active), 32'h1);
		instr_done <= 1'b1;
		wait_idle(1'b0);
		chk(32'(dac_active), 32'h0);
		n = 0;
		repeat (4) begin
			@(posedge clk_sys);
			n += periph_en + core_run_en;
		end
		chk(32'(n), 32'h2);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h5a);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd & 32'h1, 32'h1);
		irq_pending <= 1'b1;
		repeat (8) if (irq_vector_req !== 1'b1) @(posedge clk_sys);
		chk(32'(irq_vector_req), 32'h1);
		chk(32'(dac_active), 32'h1);
		irq_pending <= 1'b0;
		repeat (10) @(posedge clk_sys);
		apb(1'b1, 12'h00c, 32'ha5);
		chk(32'(dac_code), 32'ha5);
	endtask
	task automatic t_rst_idle;
		apb(1'b1, 12'h008, 32'h1);
		wait_idle(1'b0);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		chk(32'(dac_active), 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd & 32'h1, 32'h0);
		chk(32'(dac_code), 32'h0);
	endtask
	task automatic t_ports;
		ext_b <= 8'h2d;
		repeat (4) @(posedge clk_sys);
		chk(32'({array_ext_clock_in, timer_one_ext_clk, timer_zero_ext_clk,
			ext_irq_one, serial_rx, ext_irq_zero}), 32'h2f);
		apb(1'b1, 12'h014, 32'h3);
		apb(1'b1, 12'h018, 32'hf0);
		repeat (4) @(posedge clk_sys);
		apb(1'b0, 12'h01c, 32'h0);
		chk(rd, 32'h2003);
		chk(32'({port_a_oe_b, port_b_oe_b}), 32'h0f0);
		apb(1'b0, 12'h020, 32'h0);
		chk(rd, 32'h0); // refused read returns zero
		chk(32'(err), 32'h1);
		array_clock_out <= 1'b0;
		@(posedge clk_sys);
		chk(32'(port_a_out), 32'h1);
	endtask
	// ==========================================================================
	// run control
	task automatic results;
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		#100us;
		fails++;
		results;
	end
	initial begin
		rst_b = 1'b0;
		{psel, penable, pwrite, instr_done, irq_pending} = 5'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ext_a = 3'h7;
		ext_b = 8'hff;
		deflect = 3'h0;
		array_clock_out = 1'b1;
		ref_level = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		t_reset;
		t_analog;
		t_cmp;
		t_idle;
		t_rst_idle;
		t_ports;
		results;
	end
endmodule // tb_top
`default_nettype wire
